//--- dv/omc_mgmt_src.sv
// Platform model that raises management interrupts on the pin or as a message
`timescale 1ns/1ps
module omc_mgmt_src (
  // Clock and reset
  input  wire logic ref_clk_i,
  input  wire logic rst_n_i,
  // Commands from the bench
  input  wire logic fire_pin_i,
  input  wire logic fire_msg_i,
  // Interrupt lines
  output logic      pin_n_o,
  output logic      msg_o
);
  logic [2:0] low_q;
  // Pin idles high at its pull-up level and is held low four cycles per event
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_q <= 3'h0;
      msg_o <= 1'b0;
    end else begin
      low_q <= fire_pin_i ? 3'h4 : (low_q != 3'h0 ? low_q - 3'h1 : 3'h0);
      msg_o <= fire_msg_i;
    end
  end
  assign pin_n_o = (low_q == 3'h0);
endmodule : omc_mgmt_src

//--- dv/omc_mode_ctrl_monitor.sv
// Assertion checker for the operating-mode control ports
`timescale 1ns/1ps
module omc_mon (
  // Clock, reset and requests
  input wire logic       REF_CLK_I,
  input wire logic       RST_N_I,
  input wire logic       AIC_MGMT_MSG_I,
  input wire logic       MGMT_RESUME_I,
  input wire logic       INSN_VALID_I,
  input wire logic       INSN_EXT_PFX_I,
  input wire logic       INSN_EXT_W_I,
  input wire logic       INSN_OPSZ_OVR_I,
  input wire logic       MSR_REQ_I,
  input wire logic       MSR_WRITE_I,
  input wire logic       MSR_IS_TSC_I,
  input wire logic       MSR_USER_I,
  // Design outputs
  input wire logic [2:0] MODE_O,
  input wire logic       MGMT_ACTIVE_O,
  input wire logic       MGMT_SPACE_O,
  input wire logic       CTX_SAVE_O,
  input wire logic       CTX_RESTORE_O,
  input wire logic       VLEG_EN_O,
  input wire logic       HW_TASK_EN_O,
  input wire logic [4:0] GPR_CNT_O,
  input wire logic [4:0] SIMD_CNT_O,
  input wire logic [6:0] GPR_WIDTH_O,
  input wire logic [2:0] SEG_CNT_O,
  input wire logic [6:0] LIN_BITS_O,
  input wire logic [6:0] PHYS_BITS_O,
  input wire logic       DEC_VALID_O,
  input wire logic [1:0] OPND_SIZE_O,
  input wire logic [1:0] ADDR_SIZE_O,
  input wire logic       EXT_REGS_O,
  input wire logic       MSR_GRANT_O,
  input wire logic       MSR_FAULT_O
);
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!RST_N_I);

  property p_rst; $rose(RST_N_I) |-> MODE_O == 3'h0 && !MGMT_ACTIVE_O; endproperty
  a_rst: assert property (p_rst) else $error("mode not real after reset");
  property p_entry;
    AIC_MGMT_MSG_I && !MGMT_ACTIVE_O |=> CTX_SAVE_O && MGMT_ACTIVE_O ##1 MODE_O == 3'h5;
  endproperty
  a_entry: assert property (p_entry) else $error("management entry late");
  property p_space;
    MGMT_SPACE_O == MGMT_ACTIVE_O && ((MODE_O == 3'h5) == $past(MGMT_ACTIVE_O));
  endproperty
  a_space: assert property (p_space) else $error("dedicated space mismatch");
  property p_exit; MGMT_ACTIVE_O && MGMT_RESUME_I |=> CTX_RESTORE_O && !MGMT_ACTIVE_O; endproperty
  a_exit: assert property (p_exit) else $error("management exit wrong");
  property p_wide;
    INSN_VALID_I && MODE_O == 3'h4 |=> DEC_VALID_O && ADDR_SIZE_O == 2'h2
      && EXT_REGS_O == $past(INSN_EXT_PFX_I) && OPND_SIZE_O ==
      ($past(INSN_EXT_PFX_I && INSN_EXT_W_I) ? 2'h2 : ($past(INSN_OPSZ_OVR_I) ? 2'h0 : 2'h1));
  endproperty
  a_wide: assert property (p_wide) else $error("wide sizes wrong");
  property p_legacy;
    INSN_VALID_I && MODE_O inside {3'h1, 3'h3} |=> DEC_VALID_O && OPND_SIZE_O != 2'h2
      && ADDR_SIZE_O != 2'h2;
  endproperty
  a_legacy: assert property (p_legacy) else $error("legacy sizes wrong");
  property p_shape_w;
    $past(MODE_O) == 3'h4 |-> GPR_CNT_O == 5'h10 && SIMD_CNT_O == 5'h10
      && GPR_WIDTH_O == 7'h40 && LIN_BITS_O == 7'h40;
  endproperty
  a_shape_w: assert property (p_shape_w) else $error("wide shape wrong");
  property p_shape_n;
    $past(MODE_O) != 3'h4 |-> GPR_CNT_O == 5'h08 && SIMD_CNT_O == 5'h08
      && SEG_CNT_O == 3'h6 && LIN_BITS_O <= 7'h20 && PHYS_BITS_O <= 7'h24;
  endproperty
  a_shape_n: assert property (p_shape_n) else $error("legacy shape wrong");
  property p_task;
    VLEG_EN_O == ($past(MODE_O) == 3'h2)
      && HW_TASK_EN_O == ($past(MODE_O) inside {3'h1, 3'h2});
  endproperty
  a_task: assert property (p_task) else $error("task features wrong");
  property p_msr;
    MSR_REQ_I |=> MSR_GRANT_O != MSR_FAULT_O
      && MSR_FAULT_O == $past(MSR_USER_I && !(MSR_IS_TSC_I && !MSR_WRITE_I));
  endproperty
  a_msr: assert property (p_msr) else $error("register access check wrong");
endmodule : omc_mon

bind omc_mode_ctrl omc_mon u_mon (.REF_CLK_I(REF_CLK_I), .RST_N_I(RST_N_I),
  .AIC_MGMT_MSG_I(AIC_MGMT_MSG_I), .MGMT_RESUME_I(MGMT_RESUME_I), .INSN_VALID_I(INSN_VALID_I),
  .INSN_EXT_PFX_I(INSN_EXT_PFX_I), .INSN_EXT_W_I(INSN_EXT_W_I), .MSR_REQ_I(MSR_REQ_I),
  .INSN_OPSZ_OVR_I(INSN_OPSZ_OVR_I), .MSR_WRITE_I(MSR_WRITE_I), .MSR_IS_TSC_I(MSR_IS_TSC_I),
  .MSR_USER_I(MSR_USER_I), .MODE_O(MODE_O), .MGMT_ACTIVE_O(MGMT_ACTIVE_O),
  .MGMT_SPACE_O(MGMT_SPACE_O), .CTX_SAVE_O(CTX_SAVE_O), .CTX_RESTORE_O(CTX_RESTORE_O),
  .VLEG_EN_O(VLEG_EN_O), .HW_TASK_EN_O(HW_TASK_EN_O), .GPR_CNT_O(GPR_CNT_O),
  .SIMD_CNT_O(SIMD_CNT_O), .GPR_WIDTH_O(GPR_WIDTH_O), .SEG_CNT_O(SEG_CNT_O),
  .LIN_BITS_O(LIN_BITS_O), .PHYS_BITS_O(PHYS_BITS_O), .DEC_VALID_O(DEC_VALID_O),
  .OPND_SIZE_O(OPND_SIZE_O), .ADDR_SIZE_O(ADDR_SIZE_O), .EXT_REGS_O(EXT_REGS_O),
  .MSR_GRANT_O(MSR_GRANT_O), .MSR_FAULT_O(MSR_FAULT_O));

//--- dv/operating_mode_control_bench.sv
// Self-checking bench for the operating-mode control block
`timescale 1ns/1ps
module operating_mode_control_bench;
  import omc_pkg::*;
  typedef struct packed {
    logic [31:0] cr0; logic [31:0] cr4; logic ext; logic lng; logic vl;
    logic [2:0] mode; logic [6:0] lin; logic [6:0] phys;
  } omc_row_t;
  omc_row_t rows [7] = '{
    '{32'h0, 32'h0, 1'b0, 1'b0, 1'b0, 3'h0, 7'h14, 7'h14},
    '{32'h1, 32'h0, 1'b0, 1'b0, 1'b0, 3'h1, 7'h20, 7'h20},
    '{32'h1, 32'h0, 1'b0, 1'b0, 1'b1, 3'h2, 7'h20, 7'h20},
    '{32'h8000_0001, 32'h20, 1'b1, 1'b0, 1'b1, 3'h3, 7'h20, 7'h24},
    '{32'h8000_0001, 32'h0, 1'b1, 1'b1, 1'b0, 3'h1, 7'h20, 7'h20},
    '{32'h1, 32'h20, 1'b0, 1'b0, 1'b0, 3'h1, 7'h20, 7'h24},
    '{32'h8000_0001, 32'h20, 1'b1, 1'b1, 1'b0, 3'h4, 7'h40, 7'h28}};
  logic ref_clk = 1'b0, rst_n = 1'b0, cr_wr = 1'b0, ext_en = 1'b0, cs_long = 1'b0;
  logic cs_def32 = 1'b1, vleg = 1'b0, resume = 1'b0, ins_v = 1'b0, ins_p = 1'b0;
  logic ins_w = 1'b0, ins_o = 1'b0, m_req = 1'b0, m_wr = 1'b0, m_tsc = 1'b0, m_usr = 1'b0;
  logic fire_pin = 1'b0, fire_msg = 1'b0, pin_n, msg;
  logic [2:0] cr_sel = 3'h0;
  logic [31:0] cr_wd = 32'h0, cr_rd;
  logic [2:0] mode, seg;
  logic act, spc, sav, rst_o, vl_en, hw_en, dv, xr, gnt, flt;
  logic [4:0] gpr, simd;
  logic [6:0] gw, lin, phys;
  logic [1:0] osz, asz;
  int n_fail = 0, checks = 0;

  omc_mgmt_src u_src (.ref_clk_i(ref_clk), .rst_n_i(rst_n), .fire_pin_i(fire_pin),
    .fire_msg_i(fire_msg), .pin_n_o(pin_n), .msg_o(msg));
  omc_mode_ctrl #(.CR_W(32)) uut (.REF_CLK_I(ref_clk), .RST_N_I(rst_n), .CR_WR_I(cr_wr),
    .CR_SEL_I(cr_sel), .CR_WDATA_I(cr_wd), .CR_RDATA_O(cr_rd), .EXT_EN_I(ext_en),
    .CS_LONG_I(cs_long), .CS_DEF32_I(cs_def32), .TASK_VLEG_I(vleg),
    .MGMT_INT_PIN_N_I(pin_n), .AIC_MGMT_MSG_I(msg), .MGMT_RESUME_I(resume),
    .INSN_VALID_I(ins_v), .INSN_EXT_PFX_I(ins_p), .INSN_EXT_W_I(ins_w),
    .INSN_OPSZ_OVR_I(ins_o), .MSR_REQ_I(m_req), .MSR_WRITE_I(m_wr), .MSR_IS_TSC_I(m_tsc),
    .MSR_USER_I(m_usr), .MODE_O(mode), .MGMT_ACTIVE_O(act), .MGMT_SPACE_O(spc),
    .CTX_SAVE_O(sav), .CTX_RESTORE_O(rst_o), .VLEG_EN_O(vl_en), .HW_TASK_EN_O(hw_en),
    .GPR_CNT_O(gpr), .SIMD_CNT_O(simd), .GPR_WIDTH_O(gw), .SEG_CNT_O(seg),
    .LIN_BITS_O(lin), .PHYS_BITS_O(phys), .DEC_VALID_O(dv), .OPND_SIZE_O(osz),
    .ADDR_SIZE_O(asz), .EXT_REGS_O(xr), .MSR_GRANT_O(gnt), .MSR_FAULT_O(flt));

  initial begin
    forever #50 ref_clk = ~ref_clk;
  end

  task automatic edge1(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : edge1

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic cr_write(input logic [2:0] sel, input logic [31:0] d);
    edge1(1); cr_wr <= 1'b1; cr_sel <= sel; cr_wd <= d;
    edge1(1); cr_wr <= 1'b0;
  endtask : cr_write

  task automatic cr_read(input logic [2:0] sel, input logic [31:0] exp);
    edge1(1); cr_sel <= sel;
    edge1(3); #1 chk("cr_rdata", cr_rd, exp);
  endtask : cr_read

  task automatic set_row(input int i);
    cr_write(3'h0, rows[i].cr0);
    cr_write(3'h4, rows[i].cr4);
    ext_en <= rows[i].ext; cs_long <= rows[i].lng; vleg <= rows[i].vl;
    edge1(4);
  endtask : set_row

  task automatic insn(input logic p, input logic w, input logic o);
    edge1(1); ins_v <= 1'b1; ins_p <= p; ins_w <= w; ins_o <= o;
    edge1(1); ins_v <= 1'b0;
    #1 chk("dec_valid", dv, 1'b1);
  endtask : insn

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : test_done

  initial begin
    edge1(5000);
    n_fail++;
    test_done();
  end

  initial begin
    edge1(2); rst_n <= 1'b1;
    edge1(1); #1 chk("mode", mode, 3'h0);
    chk("cr0", cr_rd, 32'h0);
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      set_row(i);
      #1 chk("mode", mode, rows[i].mode);
      chk("lin_bits", lin, rows[i].lin);
      chk("phys_bits", phys, rows[i].phys);
      chk("vleg_en", vl_en, rows[i].mode == 3'h2);
      chk("hw_task_en", hw_en, rows[i].mode inside {3'h1, 3'h2});
    end
    $display("test mode table done");
    insn(1'b1, 1'b1, 1'b0); chk("opnd", osz, SZ_64); chk("ext_regs", xr, 1'b1);
    insn(1'b0, 1'b0, 1'b1); chk("opnd", osz, SZ_16); chk("addr", asz, SZ_64);
    insn(1'b0, 1'b0, 1'b0); chk("opnd", osz, SZ_32); chk("ext_regs", xr, 1'b0);
    $display("test widths done");
    edge1(1); fire_msg <= 1'b1;
    edge1(1); fire_msg <= 1'b0;
    edge1(1); #1 chk("ctx_save", sav, 1'b1);
    edge1(1); #1 chk("mode", mode, 3'h5);
    chk("mgmt_space", spc, 1'b1);
    insn(1'b0, 1'b0, 1'b1); chk("opnd", osz, SZ_32); chk("addr", asz, SZ_16);
    cr_read(3'h0, 32'h0);
    edge1(1); resume <= 1'b1;
    edge1(1); resume <= 1'b0;
    #1 chk("ctx_restore", rst_o, 1'b1);
    cr_read(3'h0, 32'h8000_0001);
    chk("mode", mode, 3'h4);
    $display("test message entry done");
    edge1(1); fire_pin <= 1'b1;
    edge1(1); fire_pin <= 1'b0;
    for (int k = 0; k < 10 && act !== 1'b1; k++) edge1(1);
    #1 chk("mgmt_active", act, 1'b1);
    edge1(1); fire_msg <= 1'b1;
    edge1(1); fire_msg <= 1'b0; resume <= 1'b1;
    edge1(1); resume <= 1'b0;
    edge1(1); #1 chk("mgmt_active", act, 1'b1);
    edge1(1); resume <= 1'b1;
    edge1(1); resume <= 1'b0;
    $display("test pin and pending done");
    cr_write(3'h5, 32'hffff_ffff);
    cr_read(3'h5, 32'h0);
    cr_write(3'h2, 32'h1234_5678);
    cr_read(3'h2, 32'h1234_5678);
    set_row(3);
    insn(1'b0, 1'b0, 1'b1); chk("opnd", osz, SZ_16); chk("addr", asz, SZ_32);
    for (int j = 0; j < 4; j++) begin
      edge1(1); m_req <= 1'b1; m_wr <= (j != 1); m_tsc <= j inside {1, 2}; m_usr <= (j != 3);
      edge1(1); m_req <= 1'b0;
      #1 chk("msr_fault", flt, j inside {0, 2});
      chk("msr_grant", gnt, j inside {1, 3});
    end
    $display("test access check done");
    edge1(1); rst_n <= 1'b0;
    edge1(2); rst_n <= 1'b1;
    edge1(1); #1 chk("mode", mode, 3'h0);
    $display("test second reset done");
    test_done();
  end
endmodule : operating_mode_control_bench

//--- rtl/omc_consts.svh
// Constants for the operating-mode control block
`ifndef OMC_CONSTS_SVH
`define OMC_CONSTS_SVH

// Control register file
`define OMC_NUM_CR          5
`define OMC_CR_SEL_W        3
`define OMC_CR_RST          32'h0000_0000
`define OMC_CR0_PE_BIT      0
`define OMC_CR0_PG_BIT      31
`define OMC_CR4_PAE_BIT     5
`define OMC_CR0_IDX         3'h0
`define OMC_CR4_IDX         3'h4

// Address-space limits in address bits
`define OMC_LIN_BITS_REAL   7'h14
`define OMC_LIN_BITS_LEGACY 7'h20
`define OMC_LIN_BITS_WIDE   7'h40
`define OMC_PHYS_BITS_BASE  7'h20
`define OMC_PHYS_BITS_PAE   7'h24
`define OMC_PHYS_BITS_WIDE  7'h28

// Visible register sets
`define OMC_GPR_CNT_BASE    5'h08
`define OMC_GPR_CNT_WIDE    5'h10
`define OMC_SIMD_CNT_BASE   5'h08
`define OMC_SIMD_CNT_WIDE   5'h10
`define OMC_GPR_W_BASE      7'h20
`define OMC_GPR_W_WIDE      7'h40
`define OMC_SEG_CNT         3'h6

`endif

//--- rtl/omc_dec_if.sv
// Carrier between mode control and the width decoder
`timescale 1ns/1ps
interface omc_dec_if;
  import omc_pkg::*;
  omc_mode_t   mode;
  logic        physical_address_extension;
  logic        cs_def32;
  logic        opsz_ovr;
  logic        ext_pfx;
  logic        ext_w;
  omc_size_t   opnd_sz;
  omc_size_t   addr_sz;
  logic        ext_ok;
  logic        vleg_ok;
  logic        task_ok;
  logic [4:0]  gpr_cnt;
  logic [4:0]  simd_cnt;
  logic [6:0]  gpr_w;
  logic [6:0]  lin_bits;
  logic [6:0]  phys_bits;

  modport ctrl (
    output mode, physical_address_extension, cs_def32, opsz_ovr, ext_pfx, ext_w,
    input  opnd_sz, addr_sz, ext_ok, vleg_ok, task_ok, gpr_cnt, simd_cnt, gpr_w,
    input  lin_bits, phys_bits
  );
  modport dec (
    input  mode, physical_address_extension, cs_def32, opsz_ovr, ext_pfx, ext_w,
    output opnd_sz, addr_sz, ext_ok, vleg_ok, task_ok, gpr_cnt, simd_cnt, gpr_w,
    output lin_bits, phys_bits
  );
endinterface : omc_dec_if

//--- rtl/omc_mode_ctrl.sv
// Operating-mode control: mode selection, management-mode entry and exit, width selection
// How it works
// - Any reset clears the control registers so the core starts in real-address mode.
// - Protected, real-address and management modes exist; mode gates usable features.
// - Virtual legacy tasks are a per-task attribute within protected mode.
// - Management mode is entered on the pin or an interrupt-controller message.
// - Entry saves the interrupted context and selects a dedicated address space.
// - Exit restores control registers zero and four as held before the management interrupt.
// - Extended mode splits into compatible and wide sub-modes by code-segment attribute.
// - Compatible sub-mode allows no virtual legacy tasks and no hardware task switching.
// - Compatible sub-mode limits linear space to 4 GByte, sizes 16 or 32 bit.
// - Compatible sub-mode still reaches physical space above 4 GByte by extension.
// - Wide sub-mode shows 16 general and 16 SIMD registers, general ones 64 bit.
// - Wide sub-mode accepts the register-extension prefix for extra registers.
// - Wide sub-mode defaults to 64-bit addresses and 32-bit operands.
// - Extension prefix with operand-size override changes operand size per instruction.
// - Outside wide sub-mode linear space is 4 GBytes (1 MByte in real-address and management modes), physical up to 64 GBytes.
// - Non-wide modes have eight general, six segment, flags and instruction pointer.
// - Five control registers, zero to four, set the mode and task characteristics.
// - Applications may not reach machine-specific registers except reading the time stamp.
`timescale 1ns/1ps
`include "omc_consts.svh"
module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int CR_W = 32
) (
  // Clock and reset
  input  wire logic                     REF_CLK_I,
  input  wire logic                     RST_N_I,

  // Control register port
  input  wire logic                     CR_WR_I,
  input  wire logic [`OMC_CR_SEL_W-1:0] CR_SEL_I,
  input  wire logic [CR_W-1:0]          CR_WDATA_I,
  output logic      [CR_W-1:0]          CR_RDATA_O,

  // Extended-mode enable and active code-segment attributes
  input  wire logic                     EXT_EN_I,
  input  wire logic                     CS_LONG_I,
  input  wire logic                     CS_DEF32_I,
  input  wire logic                     TASK_VLEG_I,

  // Management interrupt sources and return
  input  wire logic                     MGMT_INT_PIN_N_I,
  input  wire logic                     AIC_MGMT_MSG_I,
  input  wire logic                     MGMT_RESUME_I,

  // Instruction width request
  input  wire logic                     INSN_VALID_I,
  input  wire logic                     INSN_EXT_PFX_I,
  input  wire logic                     INSN_EXT_W_I,
  input  wire logic                     INSN_OPSZ_OVR_I,

  // Machine-specific register access check
  input  wire logic                     MSR_REQ_I,
  input  wire logic                     MSR_WRITE_I,
  input  wire logic                     MSR_IS_TSC_I,
  input  wire logic                     MSR_USER_I,

  // Mode indication
  output logic      [2:0]               MODE_O,
  output logic                          MGMT_ACTIVE_O,
  output logic                          MGMT_SPACE_O,
  output logic                          CTX_SAVE_O,
  output logic                          CTX_RESTORE_O,
  output logic                          VLEG_EN_O,
  output logic                          HW_TASK_EN_O,

  // Register-set and address-space shape
  output logic      [4:0]               GPR_CNT_O,
  output logic      [4:0]               SIMD_CNT_O,
  output logic      [6:0]               GPR_WIDTH_O,
  output logic      [2:0]               SEG_CNT_O,
  output logic      [6:0]               LIN_BITS_O,
  output logic      [6:0]               PHYS_BITS_O,

  // Instruction width answer
  output logic                          DEC_VALID_O,
  output logic      [1:0]               OPND_SIZE_O,
  output logic      [1:0]               ADDR_SIZE_O,
  output logic                          EXT_REGS_O,

  // Machine-specific register answer
  output logic                          MSR_GRANT_O,
  output logic                          MSR_FAULT_O
);

  if (CR_W < 32) begin : g_cr_w_check
    $error("CR_W must be at least 32");
  end

  if (`OMC_NUM_CR > (1 << `OMC_CR_SEL_W)) begin : g_cr_sel_check
    $error("Control register index too narrow");
  end

  typedef struct packed {
    // Pin synchroniser and edge detector
    logic                                pin_s1;
    logic                                pin_s2;
    logic                                pin_prev;

    // Management state
    logic                                mgmt;
    logic                                pend;

    // Control registers and their shadows
    logic [`OMC_NUM_CR-1:0][CR_W-1:0]    cr;
    logic [CR_W-1:0]                     sh_cr0;
    logic [CR_W-1:0]                     sh_cr4;

    // Registered mode, read data and pulses
    omc_mode_t                           mode;
    logic [CR_W-1:0]                     rdata;
    logic                                save;
    logic                                restore;
    logic                                vleg;
    logic                                task_en;

    // Mode-dependent shape
    logic [4:0]                          gpr_cnt;
    logic [4:0]                          simd_cnt;
    logic [6:0]                          gpr_w;
    logic [6:0]                          lin_bits;
    logic [6:0]                          phys_bits;

    // Width answer
    logic                                dec_valid;
    omc_size_t                           opnd_sz;
    omc_size_t                           addr_sz;
    logic                                ext_regs;

    // Access check answer
    logic                                msr_grant;
    logic                                msr_fault;
  } omc_state_t;

  omc_state_t st_q;
  omc_state_t st_d;

  // One width decoder serves every consumer of the mode
  omc_dec_if dec_if ();

  omc_width_dec u_width_dec (
    .d (dec_if.dec)
  );

  // Single encoded mode from control bits, segment attribute and management flag
  function automatic omc_mode_t mode_of(
    input logic [CR_W-1:0] cr0,
    input logic [CR_W-1:0] cr4,
    input logic            ext_en,
    input logic            cs_long,
    input logic            vleg,
    input logic            mgmt
  );
    if (mgmt) begin
      return MODE_MGMT;
    end

    if (!cr0[`OMC_CR0_PE_BIT]) begin
      return MODE_REAL;
    end

    if (ext_en && cr0[`OMC_CR0_PG_BIT] && cr4[`OMC_CR4_PAE_BIT]) begin
      return cs_long ? MODE_WIDE : MODE_COMPAT;
    end

    return vleg ? MODE_VLEG : MODE_PROT;
  endfunction : mode_of

  // Indices above four are unmapped
  function automatic logic cr_sel_ok(input logic [`OMC_CR_SEL_W-1:0] sel);
    return sel < `OMC_CR_SEL_W'(`OMC_NUM_CR);
  endfunction : cr_sel_ok

  // Applications may only read the time stamp
  function automatic logic msr_denied(input logic user, input logic wr, input logic tsc);
    return user && !(tsc && !wr);
  endfunction : msr_denied

  // Falling edge of the synchronised active-low pin
  function automatic logic fell(input logic prev, input logic cur);
    return prev && !cur;
  endfunction : fell

  // Decoder is fed from registered mode so all consumers see one value
  assign dec_if.mode     = st_q.mode;
  assign dec_if.physical_address_extension      = st_q.cr[`OMC_CR4_IDX][`OMC_CR4_PAE_BIT];
  // Per-instruction qualifiers pass straight through
  assign dec_if.cs_def32 = CS_DEF32_I;
  assign dec_if.opsz_ovr = INSN_OPSZ_OVR_I;
  assign dec_if.ext_pfx  = INSN_EXT_PFX_I;
  assign dec_if.ext_w    = INSN_EXT_W_I;

  always_comb begin
    logic mgmt_evt;
    logic take;
    mgmt_evt = 1'b0;
    take     = 1'b0;
    st_d     = st_q;

    // Pin crosses in through two flops; only the second is examined
    st_d.pin_s1   = MGMT_INT_PIN_N_I;
    st_d.pin_s2   = st_q.pin_s1;
    st_d.pin_prev = st_q.pin_s2;
    mgmt_evt = fell(st_q.pin_prev, st_q.pin_s2) || AIC_MGMT_MSG_I;

    st_d.save    = 1'b0;
    st_d.restore = 1'b0;

    // Control register writes; exit in the same cycle wins, entry in the same cycle only clears the PE and PG bits of register zero
    if (CR_WR_I && cr_sel_ok(CR_SEL_I)) begin
      st_d.cr[CR_SEL_I] = CR_WDATA_I;
    end

    // Entry and exit of management mode
    if (st_q.mgmt) begin
      if (MGMT_RESUME_I) begin
        st_d.mgmt = 1'b0;
        st_d.cr[`OMC_CR0_IDX] = st_q.sh_cr0;
        st_d.cr[`OMC_CR4_IDX] = st_q.sh_cr4;
        st_d.restore = 1'b1;
      end

      // An event during management waits; it beats the exit clear
      if (mgmt_evt) begin
        st_d.pend = 1'b1;
      end
    end else begin
      // A pending event enters as soon as the exit is done
      take = mgmt_evt || st_q.pend;
      if (take) begin
        st_d.mgmt   = 1'b1;
        st_d.pend   = 1'b0;
        st_d.sh_cr0 = st_q.cr[`OMC_CR0_IDX];
        st_d.sh_cr4 = st_q.cr[`OMC_CR4_IDX];
        st_d.cr[`OMC_CR0_IDX][`OMC_CR0_PE_BIT] = 1'b0;
        st_d.cr[`OMC_CR0_IDX][`OMC_CR0_PG_BIT] = 1'b0;
        st_d.save = 1'b1;
      end
    end

    st_d.mode = mode_of(st_q.cr[`OMC_CR0_IDX],
                        st_q.cr[`OMC_CR4_IDX],
                        EXT_EN_I,
                        CS_LONG_I,
                        TASK_VLEG_I,
                        st_q.mgmt);

    // Unmapped indices read as zero
    if (cr_sel_ok(CR_SEL_I)) begin
      st_d.rdata = st_q.cr[CR_SEL_I];
    end else begin
      st_d.rdata = '0;
    end

    // Mode-dependent shape, taken from the decoder on every cycle
    st_d.vleg      = dec_if.vleg_ok && (st_q.mode == MODE_VLEG);
    st_d.task_en   = dec_if.task_ok;
    st_d.gpr_cnt   = dec_if.gpr_cnt;
    st_d.simd_cnt  = dec_if.simd_cnt;
    st_d.gpr_w     = dec_if.gpr_w;
    st_d.lin_bits  = dec_if.lin_bits;
    st_d.phys_bits = dec_if.phys_bits;

    // Per-instruction widths answer one cycle after the request
    st_d.dec_valid = INSN_VALID_I;
    if (INSN_VALID_I) begin
      st_d.opnd_sz  = dec_if.opnd_sz;
      st_d.addr_sz  = dec_if.addr_sz;
      st_d.ext_regs = dec_if.ext_ok;
    end

    // Applications only read the time stamp; everything else faults
    st_d.msr_grant = 1'b0;
    st_d.msr_fault = 1'b0;
    if (MSR_REQ_I) begin
      if (msr_denied(MSR_USER_I, MSR_WRITE_I, MSR_IS_TSC_I)) begin
        st_d.msr_fault = 1'b1;
      end else begin
        st_d.msr_grant = 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      st_q           <= '0;
      // Pin chain idles released so reset gives no false edge
      st_q.pin_s1    <= 1'b1;
      st_q.pin_s2    <= 1'b1;
      st_q.pin_prev  <= 1'b1;
      st_q.cr        <= {`OMC_NUM_CR{CR_W'(`OMC_CR_RST)}};
      st_q.mode      <= MODE_REAL;
      // Shape starts at the real-address values
      st_q.gpr_cnt   <= `OMC_GPR_CNT_BASE;
      st_q.simd_cnt  <= `OMC_SIMD_CNT_BASE;
      st_q.gpr_w     <= `OMC_GPR_W_BASE;
      st_q.lin_bits  <= `OMC_LIN_BITS_REAL;
      st_q.phys_bits <= `OMC_LIN_BITS_REAL;
      st_q.opnd_sz   <= SZ_16;
      st_q.addr_sz   <= SZ_16;
    end else begin
      st_q <= st_d;
    end
  end

  // Registered read data
  assign CR_RDATA_O    = st_q.rdata;

  // Mode and management indication
  assign MODE_O        = st_q.mode;
  assign MGMT_ACTIVE_O = st_q.mgmt;
  assign MGMT_SPACE_O  = st_q.mgmt;
  assign CTX_SAVE_O    = st_q.save;
  assign CTX_RESTORE_O = st_q.restore;
  assign VLEG_EN_O     = st_q.vleg;
  assign HW_TASK_EN_O  = st_q.task_en;

  // Register-set and address-space shape
  assign GPR_CNT_O     = st_q.gpr_cnt;
  assign SIMD_CNT_O    = st_q.simd_cnt;
  assign GPR_WIDTH_O   = st_q.gpr_w;
  // Segment register count is the same in every mode
  assign SEG_CNT_O     = `OMC_SEG_CNT;
  assign LIN_BITS_O    = st_q.lin_bits;
  assign PHYS_BITS_O   = st_q.phys_bits;

  // Instruction width answer
  assign DEC_VALID_O   = st_q.dec_valid;
  assign OPND_SIZE_O   = st_q.opnd_sz;
  assign ADDR_SIZE_O   = st_q.addr_sz;
  assign EXT_REGS_O    = st_q.ext_regs;

  // Access check answer
  assign MSR_GRANT_O   = st_q.msr_grant;
  assign MSR_FAULT_O   = st_q.msr_fault;

endmodule : omc_mode_ctrl

//--- rtl/omc_pkg.sv
// Types shared by the operating-mode control block
package omc_pkg;

  // Encoded current mode used by decode, register file and address generation
  typedef enum logic [2:0] {
    MODE_REAL,
    MODE_PROT,
    MODE_VLEG,
    MODE_COMPAT,
    MODE_WIDE,
    MODE_MGMT
  } omc_mode_t;

  typedef enum logic [1:0] {
    SZ_16,
    SZ_32,
    SZ_64
  } omc_size_t;

endpackage : omc_pkg

//--- rtl/omc_width_dec.sv
// Width, register-count and address-limit decoder driven by the current mode
`timescale 1ns/1ps
`include "omc_consts.svh"
module omc_width_dec
  import omc_pkg::*;
(
  omc_dec_if.dec d
);

  function automatic omc_size_t flip16(input omc_size_t s, input logic ovr);
    if (!ovr) begin
      return s;
    end
    return (s == SZ_16) ? SZ_32 : SZ_16;
  endfunction : flip16

  always_comb begin
    d.ext_ok    = 1'b0;
    d.vleg_ok   = 1'b0;
    d.task_ok   = 1'b0;
    d.gpr_cnt   = `OMC_GPR_CNT_BASE;
    d.simd_cnt  = `OMC_SIMD_CNT_BASE;
    d.gpr_w     = `OMC_GPR_W_BASE;
    d.lin_bits  = `OMC_LIN_BITS_LEGACY;
    d.phys_bits = d.physical_address_extension ? `OMC_PHYS_BITS_PAE : `OMC_PHYS_BITS_BASE;
    d.addr_sz   = d.cs_def32 ? SZ_32 : SZ_16;
    d.opnd_sz   = flip16(d.cs_def32 ? SZ_32 : SZ_16, d.opsz_ovr);
    case (d.mode)
      MODE_REAL, MODE_MGMT: begin
        d.lin_bits  = `OMC_LIN_BITS_REAL;
        d.phys_bits = `OMC_LIN_BITS_REAL;
        d.addr_sz   = SZ_16;
        d.opnd_sz   = flip16(SZ_16, d.opsz_ovr);
      end
      MODE_PROT, MODE_VLEG: begin
        d.task_ok = 1'b1;
        d.vleg_ok = 1'b1;
      end
      MODE_COMPAT: begin
        // Legacy-compatible: no virtual legacy tasks, no hardware task switching
        d.phys_bits = `OMC_PHYS_BITS_PAE;
        d.lin_bits  = `OMC_LIN_BITS_LEGACY;
      end
      MODE_WIDE: begin
        d.gpr_cnt   = `OMC_GPR_CNT_WIDE;
        d.simd_cnt  = `OMC_SIMD_CNT_WIDE;
        d.gpr_w     = `OMC_GPR_W_WIDE;
        d.lin_bits  = `OMC_LIN_BITS_WIDE;
        d.phys_bits = `OMC_PHYS_BITS_WIDE;
        d.ext_ok    = d.ext_pfx;
        d.addr_sz   = SZ_64;
        if (d.ext_pfx && d.ext_w) begin
          d.opnd_sz = SZ_64;
        end else if (d.opsz_ovr) begin
          d.opnd_sz = SZ_16;
        end else begin
          d.opnd_sz = SZ_32;
        end
      end
      default: begin
        d.addr_sz = SZ_16;
      end
    endcase
  end

endmodule : omc_width_dec
